// ---- hw/sram_ctrl_params.svh ----
// Timing constants for the asynchronous SRAM host controller
// What this block does
// - A write starts when select and strobe are low; one lane writes a byte, both a word.
// - A controller that gates writes with the lane selects keeps the width select high; this one drives it from req_word, low for byte requests.
// - The active-low select is held low at least 70 ns before each write ends.
// - The address is stable at least 70 ns before each write ends.
// - The lane selects are active at least 70 ns before each write ends.
// - The write pulse lasts at least 60 ns.
// - Write data is valid at least 35 ns before the write ends.
`ifndef SRAM_CTRL_PARAMS_SVH
`define SRAM_CTRL_PARAMS_SVH
`define CLK_PERIOD_NS 100
`define T_ACCESS_NS 85
`define T_OE_ACCESS_NS 45
`define T_LANE_ACCESS_NS 85
`define T_SEL_TO_END_NS 70
`define T_ADDR_TO_END_NS 70
`define T_LANE_TO_END_NS 70
`define T_WRITE_PULSE_NS 60
`define T_DATA_SETUP_NS 35
`define T_FLOAT_NS 25
`define CEILCYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAXOF(a, b) (((a) > (b)) ? (a) : (b))
// Read waits for the slowest access path, rounded up to whole clock cycles
`define READ_WAIT_CYC `MAXOF(`CEILCYC(`T_ACCESS_NS), `CEILCYC(`T_LANE_ACCESS_NS))
`define WRITE_PULSE_CYC `MAXOF(`MAXOF(`CEILCYC(`T_WRITE_PULSE_NS), `CEILCYC(`T_SEL_TO_END_NS)), \
   `MAXOF(`CEILCYC(`T_ADDR_TO_END_NS), `MAXOF(`CEILCYC(`T_LANE_TO_END_NS), \
   `CEILCYC(`T_DATA_SETUP_NS))))
`define FLOAT_CYC `CEILCYC(`T_FLOAT_NS)
`endif

// ---- hw/sram_ctrl_pkg.sv ----
// Types shared by the SRAM host controller
package sram_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_WAIT,
      ST_RD_SAMPLE,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_WR_END,
      ST_TURN
   } ctrl_state_t;
endpackage

// ---- hw/cycle_timer.sv ----
// Down counter that times the phases of a bus cycle
`include "sram_ctrl_params.svh"
module cycle_timer #(
   parameter int WIDTH = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   output logic done
);
   logic [WIDTH-1:0] count_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         count_q <= '0;
      else if (load)
         count_q <= load_value;
      else if (count_q != '0)
         count_q <= count_q - WIDTH'(1);
   end

   assign done = (count_q == '0) && !load;
endmodule

// ---- hw/sram_host_ctrl.sv ----
// Host controller that runs read and write cycles on an asynchronous SRAM
`include "sram_ctrl_params.svh"
module sram_host_ctrl
   import sram_ctrl_pkg::*;
#(
   parameter int ADDR_WIDTH = 18,
   parameter int DATA_WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   // User request side
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_word,
   input wire logic [1:0] req_lanes,
   input wire logic [ADDR_WIDTH-1:0] req_addr,
   input wire logic [DATA_WIDTH-1:0] req_wdata,
   output logic rsp_valid,
   output logic [DATA_WIDTH-1:0] rsp_rdata,
   // SRAM pins
   output logic [ADDR_WIDTH-1:0] sram_addr,
   output logic sram_select_active_low,
   output logic sram_select_active_high,
   output logic output_drive_enable_n,
   output logic write_strobe_n,
   output logic upper_lane_select_n,
   output logic lower_lane_select_n,
   output logic word_width_select,
   input wire logic [DATA_WIDTH-1:0] sram_data_in,
   output logic [DATA_WIDTH-1:0] sram_data_out,
   output logic sram_data_oe
);
   localparam int TW = 4;
   localparam logic [TW-1:0] READ_LOAD = TW'(`READ_WAIT_CYC);
   localparam logic [TW-1:0] WPULSE_LOAD = TW'(`WRITE_PULSE_CYC - 1);
   localparam logic [TW-1:0] FLOAT_LOAD = TW'(`FLOAT_CYC - 1);

   ctrl_state_t state_q;
   logic timer_load;
   logic [TW-1:0] timer_value;
   logic timer_done;
   logic [DATA_WIDTH-1:0] din_meta_q;
   logic [DATA_WIDTH-1:0] din_sync_q;

   cycle_timer #(.WIDTH(TW)) timer_u (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(timer_load),
      .load_value(timer_value),
      .done(timer_done)
   );

   assign req_ready = (state_q == ST_IDLE);

   // ----------------------------------------------------------------
   // Read data synchroniser
   // ----------------------------------------------------------------
   // The SRAM is clockless, so its data pins pass two flops first
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         din_meta_q <= '0;
         din_sync_q <= '0;
      end
      else
      begin
         din_meta_q <= sram_data_in;
         din_sync_q <= din_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Timer loads
   // ----------------------------------------------------------------
   always_comb
   begin
      timer_load = 1'b0;
      timer_value = '0;
      case (state_q)
         ST_IDLE:
         begin
            if (req_valid)
            begin
               timer_load = 1'b1;
               timer_value = req_write ? '0 : READ_LOAD;
            end
         end
         ST_WR_SETUP:
         begin
            timer_load = 1'b1;
            timer_value = WPULSE_LOAD;
         end
         ST_RD_SAMPLE, ST_WR_END:
         begin
            timer_load = 1'b1;
            timer_value = FLOAT_LOAD;
         end
         default:
         begin
            timer_load = 1'b0;
            timer_value = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
               if (req_valid)
                  state_q <= req_write ? ST_WR_SETUP : ST_RD_WAIT;
            ST_RD_WAIT:
               if (timer_done)
                  state_q <= ST_RD_SAMPLE;
            ST_RD_SAMPLE:
               state_q <= ST_TURN;
            ST_WR_SETUP:
               state_q <= ST_WR_PULSE;
            ST_WR_PULSE:
               if (timer_done)
                  state_q <= ST_WR_END;
            ST_WR_END:
               state_q <= ST_TURN;
            ST_TURN:
               if (timer_done)
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Address, width and lane pins, latched at request
   // ----------------------------------------------------------------
   // Held through the whole cycle so setup and hold come for free
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sram_addr <= '0;
         word_width_select <= 1'b1;
         upper_lane_select_n <= 1'b1;
         lower_lane_select_n <= 1'b1;
         sram_data_out <= '0;
      end
      else if (state_q == ST_IDLE && req_valid)
      begin
         sram_addr <= req_addr;
         word_width_select <= req_word;
         upper_lane_select_n <= !(req_word && req_lanes[1]);
         lower_lane_select_n <= !(req_word ? req_lanes[0] : 1'b1);
         sram_data_out <= req_wdata;
      end
      else if (state_q == ST_TURN && timer_done)
      begin
         upper_lane_select_n <= 1'b1;
         lower_lane_select_n <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Strobe pins
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sram_select_active_low <= 1'b1;
         sram_select_active_high <= 1'b0;
         output_drive_enable_n <= 1'b1;
         write_strobe_n <= 1'b1;
         sram_data_oe <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (req_valid)
               begin
                  sram_select_active_low <= 1'b0;
                  sram_select_active_high <= 1'b1;
                  output_drive_enable_n <= req_write;
                  write_strobe_n <= 1'b1;
               end
            end
            ST_WR_SETUP:
            begin
               write_strobe_n <= 1'b0;
               sram_data_oe <= 1'b1;
            end
            ST_WR_PULSE:
               if (timer_done)
                  write_strobe_n <= 1'b1;
            ST_WR_END:
            begin
               // Strobe rose last cycle; data held one more for hold time
               sram_select_active_low <= 1'b1;
               sram_select_active_high <= 1'b0;
               sram_data_oe <= 1'b0;
            end
            ST_RD_SAMPLE:
            begin
               sram_select_active_low <= 1'b1;
               sram_select_active_high <= 1'b0;
               output_drive_enable_n <= 1'b1;
            end
            default:
            begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read answer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else
      begin
         rsp_valid <= (state_q == ST_RD_SAMPLE);
         if (state_q == ST_RD_SAMPLE)
            rsp_rdata <= din_sync_q;
      end
   end
endmodule

// ---- test/sram_host_ctrl_properties.sv ----
// Pin timing checks for the SRAM host controller
module sram_host_ctrl_checker #(
   parameter int ADDR_WIDTH = 18,
   parameter int DATA_WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic rsp_valid,
   input wire logic [ADDR_WIDTH-1:0] sram_addr,
   input wire logic sram_select_active_low,
   input wire logic output_drive_enable_n,
   input wire logic write_strobe_n,
   input wire logic upper_lane_select_n,
   input wire logic lower_lane_select_n,
   input wire logic word_width_select,
   input wire logic [DATA_WIDTH-1:0] sram_data_out,
   input wire logic sram_data_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_wr_take;
      req_valid && req_ready && req_write;
   endsequence
   sequence s_rd_take;
      req_valid && req_ready && !req_write;
   endsequence
   sequence s_pulse;
      !write_strobe_n ##1 write_strobe_n;
   endsequence
   property p_oe_we_excl;
      !(!output_drive_enable_n && !write_strobe_n);
   endproperty
   property p_sel_hold;
      $fell(write_strobe_n) |-> $past(!sram_select_active_low) ##1 !sram_select_active_low;
   endproperty
   property p_addr_stable;
      $fell(write_strobe_n) |-> $stable(sram_addr) ##1 $stable(sram_addr);
   endproperty
   property p_lane_stable;
      !write_strobe_n |-> $stable({upper_lane_select_n, lower_lane_select_n});
   endproperty
   property p_width_stable;
      !write_strobe_n |-> $stable(word_width_select);
   endproperty
   property p_pulse;
      s_wr_take |-> ##2 s_pulse;
   endproperty
   property p_data_setup;
      !write_strobe_n |-> sram_data_oe && $stable(sram_data_out);
   endproperty
   property p_read_we;
      s_rd_take |=> write_strobe_n [*4];
   endproperty
   property p_read_ans;
      s_rd_take |=> !rsp_valid [*3] ##1 rsp_valid;
   endproperty
   property p_no_contend;
      sram_data_oe |-> output_drive_enable_n;
   endproperty
   a_oe_we_excl: assert property (p_oe_we_excl) else $error("oe and we low together");
   a_sel_hold: assert property (p_sel_hold) else $error("select not held in write");
   a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");
   a_lane_stable: assert property (p_lane_stable) else $error("lanes moved in write");
   a_width_stable: assert property (p_width_stable) else $error("width moved");
   a_pulse: assert property (p_pulse) else $error("write pulse wrong");
   a_data_setup: assert property (p_data_setup) else $error("write data unstable");
   a_read_we: assert property (p_read_we) else $error("strobe low in read");
   a_read_ans: assert property (p_read_ans) else $error("read answer late");
   a_no_contend: assert property (p_no_contend) else $error("bus contention");
endmodule
bind sram_host_ctrl sram_host_ctrl_checker #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH))
   i_chk (.ref_clk, .rst, .req_valid, .req_ready, .req_write, .rsp_valid, .sram_addr,
   .sram_select_active_low, .output_drive_enable_n, .write_strobe_n, .upper_lane_select_n,
   .lower_lane_select_n, .word_width_select, .sram_data_out, .sram_data_oe);

// ---- test/sram_device_model.sv ----
// Behavioural model of the asynchronous SRAM
module sram_device_model (
   input wire logic [17:0] sram_addr,
   input wire logic sram_select_active_low,
   input wire logic sram_select_active_high,
   input wire logic output_drive_enable_n,
   input wire logic write_strobe_n,
   input wire logic upper_lane_select_n,
   input wire logic lower_lane_select_n,
   input wire logic word_width_select,
   input wire logic [15:0] sram_data_out,
   output logic [15:0] sram_data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [16];
   logic [15:0] held = 16'h0000;
   logic sel, up, lo;
   assign sel = !sram_select_active_low && sram_select_active_high;
   assign up = word_width_select && !upper_lane_select_n;
   assign lo = !word_width_select || !lower_lane_select_n;
   // Stores through the whole overlap, so whichever select or strobe pin goes inactive first ends it
   always @*
   begin
      if (sel && !write_strobe_n)
      begin
         if (up) mem[sram_addr[3:0]][15:8] = sram_data_out[15:8];
         if (lo) mem[sram_addr[3:0]][7:0] = sram_data_out[7:0];
      end
   end
   // Released lanes show the inverse of the last value, so stale data never matches
   always @*
   begin
      sram_data_in = ~held;
      if (sel && !output_drive_enable_n && write_strobe_n)
      begin
         if (up) sram_data_in[15:8] = mem[sram_addr[3:0]][15:8];
         if (lo) sram_data_in[7:0] = mem[sram_addr[3:0]][7:0];
      end
   end
   always @(posedge output_drive_enable_n)
      held <= sram_data_in;
endmodule

// ---- test/tb_sram_host_ctrl.sv ----
// Self-checking bench for the SRAM host controller
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_sram_host_ctrl
   import sram_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_word = 1'b0;
   logic [1:0] req_lanes = 2'h0;
   logic [17:0] req_addr = 18'h0, sram_addr;
   logic [15:0] req_wdata = 16'h0, rsp_rdata, sram_data_in, sram_data_out;
   logic req_ready, rsp_valid, sram_select_active_low, sram_select_active_high;
   logic output_drive_enable_n, write_strobe_n, upper_lane_select_n, lower_lane_select_n;
   logic word_width_select, sram_data_oe;
   int fails = 0, tests_run = 0;
   always #50 ref_clk = ~ref_clk;
   sram_host_ctrl i_sram_host_ctrl (.ref_clk, .rst, .req_valid, .req_ready, .req_write,
      .req_word, .req_lanes, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .sram_addr,
      .sram_select_active_low, .sram_select_active_high, .output_drive_enable_n,
      .write_strobe_n, .upper_lane_select_n, .lower_lane_select_n, .word_width_select,
      .sram_data_in, .sram_data_out, .sram_data_oe);
   sram_device_model i_sram_device_model (.sram_addr, .sram_select_active_low,
      .sram_select_active_high, .output_drive_enable_n, .write_strobe_n, .upper_lane_select_n,
      .lower_lane_select_n, .word_width_select, .sram_data_out, .sram_data_in);
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Returns at the falling edge just after the taking edge
   task automatic issue(logic w, logic wd, logic [1:0] ln, logic [17:0] a, logic [15:0] d);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (req_ready !== 1'b1 && n < 20)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 20) fails++;
      req_write = w;
      req_word = wd;
      req_lanes = ln;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
   endtask
   task automatic rd(logic wd, logic [1:0] ln, logic [17:0] a, logic [15:0] m, logic [15:0] e);
      issue(1'b0, wd, ln, a, 16'h0);
      `CHK(sram_addr, a)
      `CHK(word_width_select, wd)
      repeat (3) @(negedge ref_clk);
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_rdata & m, e)
   endtask
   task automatic t_idle;
      `CHK({sram_select_active_low, sram_select_active_high, output_drive_enable_n,
         write_strobe_n, sram_data_oe}, 5'b10110)
      $display("idle pins done");
   endtask
   task automatic t_word;
      issue(1'b1, 1'b1, 2'h3, 18'h2a001, 16'h1234);
      rd(1'b1, 2'h3, 18'h2a001, 16'hffff, 16'h1234);
      $display("word write done");
   endtask
   task automatic t_lanes;
      issue(1'b1, 1'b1, 2'h3, 18'h2, 16'haaaa);
      issue(1'b1, 1'b1, 2'h2, 18'h2, 16'h3cff);
      issue(1'b1, 1'b1, 2'h1, 18'h2, 16'hff7e);
      rd(1'b1, 2'h3, 18'h2, 16'hffff, 16'h3c7e);
      rd(1'b1, 2'h1, 18'h2, 16'h00ff, 16'h007e);
      $display("lane write done");
   endtask
   task automatic t_byte;
      issue(1'b1, 1'b1, 2'h3, 18'h3, 16'h4400);
      issue(1'b1, 1'b0, 2'h0, 18'h3, 16'h9981);
      rd(1'b0, 2'h0, 18'h3, 16'h00ff, 16'h0081);
      rd(1'b1, 2'h3, 18'h3, 16'hffff, 16'h4481);
      $display("byte mode done");
   endtask
   initial
   begin
      #(400 * 100);
      fails++;
      report_and_stop();
   end
   initial
   begin
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_idle();
      t_word();
      t_lanes();
      t_byte();
      report_and_stop();
   end
endmodule
